// file: design/mbf_slave_end.sv
/*
 * Slave end of the framer: query reception and checking, timeout
 * monitor, response FIFO and response transmission with CRC.
 * Assumes a byte-level link whose bytes are synchronous to clk.
 */
`timescale 1ns/100ps

// Response byte FIFO; width and depth shape its storage.
module mbf_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D]; // Storage, written only on a push.
    logic [AW:0] wp_r, wp_nxt; // Write pointer with wrap bit.
    logic [AW:0] rp_r, rp_nxt; // Read pointer with wrap bit.
    logic push, pop;

    // Full when pointers differ only in the wrap bit.
    assign in_ready = !((wp_r[AW] != rp_r[AW]) &&
                        (wp_r[AW-1:0] == rp_r[AW-1:0]));
    assign out_valid = (wp_r != rp_r);
    assign out_data = mem[rp_r[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer advance.
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end

    // Pointer registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // Storage has no reset; it is never read while empty.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

module mbf_slave_end
    import mbf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int SILENT_SLOW = SILENT_SLOW_CYC,
    parameter int SILENT_FAST = SILENT_FAST_CYC,
    parameter int WAIT_UNIT = WAIT_UNIT_CYC,
    parameter int MS_TICK = MS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    mbf_link_if.slave link,
    input wire logic [7:0] my_addr,
    input wire logic [2:0] rate_sel,
    input wire logic [13:0] wait_cnt,
    input wire logic [13:0] timeout_ms,
    output logic qry_valid,
    output logic [7:0] qry_data,
    output logic qry_done,
    output logic qry_bcast,
    output logic qry_known,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last,
    output logic rsp_ready,
    output logic rsp_busy,
    output logic timeout_alarm
);
    import mbf_pkg::*;

    typedef enum {TX_IDLE, TX_WAIT, TX_DATA, TX_CRCL, TX_CRCH} mbf_tx_t;

    logic [31:0] silent; // Silent interval for the selected rate.
    logic rx_byte; // A byte arrives while we are not driving.
    logic [8:0] exp_len; // Length expected from the function code.
    logic frame_end; // Idle gap closes the open frame.
    logic accept; // Closed frame passed every check.

    // Receive state.
    logic in_frame_r, in_frame_nxt;
    logic [8:0] len_r, len_nxt; // Saturates just above the maximum.
    logic [15:0] rcrc_r, rcrc_nxt;
    logic err_r, err_nxt;
    logic [7:0] addr_r, addr_nxt, fc_r, fc_nxt, bcnt_r, bcnt_nxt;
    logic [31:0] idle_r, idle_nxt;
    logic qv_r, qv_nxt, qd_r, qd_nxt, qb_r, qb_nxt, qk_r, qk_nxt;
    logic [7:0] qdat_r, qdat_nxt;

    // Transmit state.
    mbf_tx_t tx_r, tx_nxt;
    logic [31:0] tcnt_r, tcnt_nxt; // Turnaround countdown.
    logic [15:0] tcrc_r, tcrc_nxt;
    logic sv_r, sv_nxt, de_r, de_nxt;
    logic [7:0] sdat_r, sdat_nxt;

    // Timeout state.
    logic [31:0] mscnt_r, mscnt_nxt;
    logic [13:0] tmo_r, tmo_nxt;
    logic alarm_r, alarm_nxt;

    // FIFO drain side.
    logic f_valid, f_ready;
    logic [8:0] f_data;

    assign silent = (rate_sel == RATE_9600) ? SILENT_SLOW
                                            : SILENT_FAST;
    // Our own transmission never reads back as a query.
    assign rx_byte = link.m_valid && !de_r;
    assign exp_len = fc_len(fc_r, bcnt_r);
    assign frame_end = in_frame_r && !rx_byte &&
                       (idle_r >= silent - 1);

    // Frame checks, evaluated when the idle gap closes the frame.
    always_comb begin
        accept = !err_r && (len_r <= LEN_MAX)
                 && (len_r >= LEN_MIN) && (rcrc_r == 16'h0000);
        if (addr_r != ADDR_BCAST && addr_r != my_addr) begin
            accept = 1'b0;
        end
        if (exp_len != 9'h000 && len_r != exp_len) begin
            accept = 1'b0;
        end
        if (fc_r == FC_WRN && (len_r < LEN_WRN_MIN ||
                               len_r > LEN_WRN_MAX)) begin
            accept = 1'b0;
        end
        // Only the two write codes may arrive as a broadcast.
        if (addr_r == ADDR_BCAST && fc_r != FC_WR1 &&
            fc_r != FC_WRN) begin
            accept = 1'b0;
        end
    end

    // Receive path: byte capture, running CRC, length and idle gap.
    always_comb begin
        in_frame_nxt = in_frame_r;
        len_nxt = len_r;
        rcrc_nxt = rcrc_r;
        err_nxt = err_r;
        addr_nxt = addr_r;
        fc_nxt = fc_r;
        bcnt_nxt = bcnt_r;
        idle_nxt = in_frame_r ? idle_r + 1 : 32'h0000_0000;
        qv_nxt = 1'b0;
        qd_nxt = 1'b0;
        qdat_nxt = qdat_r;
        qb_nxt = qb_r;
        qk_nxt = qk_r;
        if (rx_byte) begin
            // First byte of a frame restarts the CRC from all ones.
            rcrc_nxt = crc_byte(in_frame_r ? rcrc_r : CRC_INIT,
                                link.m_data);
            len_nxt = in_frame_r ? len_r : 9'h000;
            if (len_nxt <= LEN_MAX) begin
                len_nxt = len_nxt + 1'b1;
            end
            err_nxt = (in_frame_r && err_r) || link.m_err;
            if (!in_frame_r) begin
                addr_nxt = link.m_data;
            end else if (len_r == 9'h001) begin
                fc_nxt = link.m_data;
            end else if (len_r == BCNT_POS) begin
                bcnt_nxt = link.m_data;
            end
            if (!in_frame_r) begin
                fc_nxt = 8'h00;
                bcnt_nxt = 8'h00;
            end
            in_frame_nxt = 1'b1;
            idle_nxt = 32'h0000_0000;
            qv_nxt = 1'b1;
            qdat_nxt = link.m_data;
        end else if (frame_end) begin
            in_frame_nxt = 1'b0;
            qd_nxt = accept;
            qb_nxt = (addr_r == ADDR_BCAST);
            qk_nxt = (exp_len != 9'h000);
        end
    end

    // Receive registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_frame_r <= 1'b0;
            len_r <= 9'h000;
            rcrc_r <= CRC_INIT;
            err_r <= 1'b0;
            addr_r <= 8'h00;
            fc_r <= 8'h00;
            bcnt_r <= 8'h00;
            idle_r <= 32'h0000_0000;
            qv_r <= 1'b0;
            qd_r <= 1'b0;
            qdat_r <= 8'h00;
            qb_r <= 1'b0;
            qk_r <= 1'b0;
        end else begin
            in_frame_r <= in_frame_nxt;
            len_r <= len_nxt;
            rcrc_r <= rcrc_nxt;
            err_r <= err_nxt;
            addr_r <= addr_nxt;
            fc_r <= fc_nxt;
            bcnt_r <= bcnt_nxt;
            idle_r <= idle_nxt;
            qv_r <= qv_nxt;
            qd_r <= qd_nxt;
            qdat_r <= qdat_nxt;
            qb_r <= qb_nxt;
            qk_r <= qk_nxt;
        end
    end

    // Response bytes queue here while the user builds them.
    mbf_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(rsp_valid),
        .in_ready(rsp_ready),
        .in_data({rsp_last, rsp_data}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // Drain stalls until the turnaround wait is over.
    assign f_ready = (tx_r == TX_DATA);

    // Transmit sequence: turnaround, payload, then the two CRC bytes.
    always_comb begin
        tx_nxt = tx_r;
        tcnt_nxt = tcnt_r;
        tcrc_nxt = tcrc_r;
        sv_nxt = 1'b0;
        sdat_nxt = sdat_r;
        de_nxt = de_r;
        case (tx_r)
            TX_IDLE: begin
                // Driver stays on through the last CRC byte, then drops.
                de_nxt = 1'b0;
                // Broadcasts are executed by the user but never answered.
                if (qd_r && !qb_r) begin
                    de_nxt = 1'b1;
                    tcnt_nxt = silent + wait_cnt * WAIT_UNIT;
                    tx_nxt = TX_WAIT;
                end
            end
            TX_WAIT: begin
                if (tcnt_r <= 32'h0000_0001) begin
                    tcrc_nxt = CRC_INIT;
                    tx_nxt = TX_DATA;
                end else begin
                    tcnt_nxt = tcnt_r - 1;
                end
            end
            TX_DATA: begin
                if (f_valid) begin
                    sv_nxt = 1'b1;
                    sdat_nxt = f_data[7:0];
                    tcrc_nxt = crc_byte(tcrc_r, f_data[7:0]);
                    if (f_data[8]) begin
                        tx_nxt = TX_CRCL;
                    end
                end
            end
            TX_CRCL: begin
                sv_nxt = 1'b1;
                sdat_nxt = tcrc_r[7:0];
                tx_nxt = TX_CRCH;
            end
            TX_CRCH: begin
                sv_nxt = 1'b1;
                sdat_nxt = tcrc_r[15:8];
                tx_nxt = TX_IDLE;
            end
            default: begin
                de_nxt = 1'b0;
                tx_nxt = TX_IDLE;
            end
        endcase
    end

    // Transmit registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_r <= TX_IDLE;
            tcnt_r <= 32'h0000_0000;
            tcrc_r <= CRC_INIT;
            sv_r <= 1'b0;
            sdat_r <= 8'h00;
            de_r <= 1'b0;
        end else begin
            tx_r <= tx_nxt;
            tcnt_r <= tcnt_nxt;
            tcrc_r <= tcrc_nxt;
            sv_r <= sv_nxt;
            sdat_r <= sdat_nxt;
            de_r <= de_nxt;
        end
    end

    // Timeout monitor: millisecond count since the last received byte.
    // A fresh byte restarts the gap and wins over a same-cycle expiry.
    always_comb begin
        mscnt_nxt = mscnt_r + 1;
        tmo_nxt = tmo_r;
        alarm_nxt = alarm_r;
        if (mscnt_r >= MS_TICK - 1) begin
            mscnt_nxt = 32'h0000_0000;
            if (tmo_r != 14'h3FFF) begin
                tmo_nxt = tmo_r + 1'b1;
            end
        end
        if (timeout_ms != TIMEOUT_DEFAULT && tmo_r >= timeout_ms) begin
            alarm_nxt = 1'b1;
        end
        if (timeout_ms == TIMEOUT_DEFAULT || rx_byte) begin
            tmo_nxt = 14'h0000;
            mscnt_nxt = 32'h0000_0000;
            alarm_nxt = 1'b0;
        end
    end

    // Timeout registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mscnt_r <= 32'h0000_0000;
            tmo_r <= 14'h0000;
            alarm_r <= 1'b0;
        end else begin
            mscnt_r <= mscnt_nxt;
            tmo_r <= tmo_nxt;
            alarm_r <= alarm_nxt;
        end
    end

    assign link.s_valid = sv_r;
    assign link.s_data = sdat_r;
    assign link.s_de = de_r;
    assign qry_valid = qv_r;
    assign qry_data = qdat_r;
    assign qry_done = qd_r;
    assign qry_bcast = qb_r;
    assign qry_known = qk_r;
    assign rsp_busy = (tx_r != TX_IDLE);
    assign timeout_alarm = alarm_r;
endmodule

// file: design/mbf_pkg.sv
/*
 * Shared constants, timing counts and CRC helpers of the framer link.
 * Assumes a 100 MHz system clock and a byte-level link (no UART here).
 */
package mbf_pkg;
    // System clock rate and the cycles in one microsecond.
    localparam int CLK_HZ = 100_000_000;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    // Silent interval at 9600 bps and at the faster rates, in us.
    localparam int SILENT_SLOW_US = 5500;
    localparam int SILENT_FAST_US = 3500;
    // Extra spacing after a broadcast, in us.
    localparam int BCAST_EXTRA_US = 5000;
    // Unit of the turnaround wait count, and one millisecond, in us.
    localparam int WAIT_UNIT_US = 100;
    localparam int MS_US = 1000;
    // Derived cycle counts; all are far above one cycle.
    localparam int SILENT_SLOW_CYC = SILENT_SLOW_US * US_CYC;
    localparam int SILENT_FAST_CYC = SILENT_FAST_US * US_CYC;
    localparam int BCAST_EXTRA_CYC = BCAST_EXTRA_US * US_CYC;
    localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * US_CYC;
    localparam int MS_CYC = MS_US * US_CYC;
    // Rate select code for 9600 bps; other codes are the faster rates.
    localparam logic [2:0] RATE_9600 = 3'h0;
    // Addresses and supported function codes.
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WR1 = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_WRN = 8'h10;
    // Frame lengths in bytes.
    localparam logic [8:0] LEN_FIXED = 9'h008;
    localparam logic [8:0] LEN_WRN_BASE = 9'h009;
    localparam logic [8:0] LEN_WRN_MIN = 9'h00B;
    localparam logic [8:0] LEN_WRN_MAX = 9'h029;
    localparam logic [8:0] LEN_MIN = 9'h004;
    localparam logic [8:0] LEN_MAX = 9'h100;
    // Position of the byte count in a multiple-write query.
    localparam logic [8:0] BCNT_POS = 9'h006;
    // Reset values of the programmable times.
    localparam logic [13:0] WAIT_DEFAULT = 14'h0064;
    localparam logic [13:0] TIMEOUT_DEFAULT = 14'h0000;
    // CRC-16 start value and reflected polynomial.
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    // One byte into the CRC: xor low bits, then eight right shifts.
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // Expected query length for a code, zero when unsupported.
    function automatic logic [8:0] fc_len(input logic [7:0] fc,
                                          input logic [7:0] bcnt);
        case (fc)
            FC_READ, FC_WR1, FC_DIAG: fc_len = LEN_FIXED;
            FC_WRN: fc_len = LEN_WRN_BASE + {1'b0, bcnt};
            default: fc_len = 9'h000;
        endcase
    endfunction
endpackage

// file: design/mbf_link_if.sv
/*
 * Byte-level half-duplex link between the master end and the slave end.
 * Assumes both ends share clk; each end drives its own set of signals.
 */
`timescale 1ns/100ps
interface mbf_link_if;
    logic m_valid; // Master byte strobe, one cycle per byte.
    logic [7:0] m_data; // Master byte.
    logic m_err; // Byte carried a framing or parity error.
    logic m_de; // Master line driver on.
    logic s_valid; // Slave byte strobe.
    logic [7:0] s_data; // Slave byte.
    logic s_de; // Slave line driver on.
    modport master (output m_valid, m_data, m_err, m_de,
                    input s_valid, s_data, s_de);
    modport slave (input m_valid, m_data, m_err, m_de,
                   output s_valid, s_data, s_de);
endinterface

// file: design/mbf_master_end.sv
/*
 * Master end of the framer: sends queries with CRC, keeps frame spacing,
 * and collects slave responses. Assumes the byte-level link interface.
 */
`timescale 1ns/100ps
module mbf_master_end
    import mbf_pkg::*;
#(
    parameter int SILENT_SLOW = SILENT_SLOW_CYC,
    parameter int SILENT_FAST = SILENT_FAST_CYC,
    parameter int BCAST_EXTRA = BCAST_EXTRA_CYC
) (
    input wire logic clk,
    input wire logic rst,
    mbf_link_if.master link,
    input wire logic [2:0] rate_sel,
    input wire logic q_valid,
    input wire logic [7:0] q_data,
    input wire logic q_last,
    input wire logic q_err,
    output logic q_ready,
    output logic r_valid,
    output logic [7:0] r_data,
    output logic r_done,
    output logic r_crc_ok
);
    import mbf_pkg::*;

    typedef enum {M_IDLE, M_SEND, M_CRCL, M_CRCH, M_GAP} mbf_mst_t;

    logic [31:0] silent; // Silent interval for the selected rate.
    mbf_mst_t st_r, st_nxt;
    logic [15:0] crc_r, crc_nxt;
    logic bc_r, bc_nxt; // Current query is a broadcast.
    logic [31:0] gap_r, gap_nxt;
    logic mv_r, mv_nxt, me_r, me_nxt, de_r, de_nxt;
    logic [7:0] md_r, md_nxt;
    // Response collection.
    logic rin_r, rin_nxt, rv_r, rv_nxt, rd_r, rd_nxt, ok_r, ok_nxt;
    logic [15:0] rcrc_r, rcrc_nxt;
    logic [31:0] ridle_r, ridle_nxt;
    logic [7:0] rdat_r, rdat_nxt;

    assign silent = (rate_sel == RATE_9600) ? SILENT_SLOW
                                            : SILENT_FAST;
    assign q_ready = (st_r == M_IDLE) || (st_r == M_SEND);

    // Query sender and inter-frame spacing.
    always_comb begin
        st_nxt = st_r;
        crc_nxt = crc_r;
        bc_nxt = bc_r;
        gap_nxt = gap_r;
        mv_nxt = 1'b0;
        md_nxt = md_r;
        me_nxt = 1'b0;
        de_nxt = de_r;
        case (st_r)
            M_IDLE, M_SEND: begin
                if (q_valid) begin
                    mv_nxt = 1'b1;
                    md_nxt = q_data;
                    me_nxt = q_err;
                    de_nxt = 1'b1;
                    crc_nxt = crc_byte((st_r == M_IDLE) ? CRC_INIT : crc_r,
                                       q_data);
                    if (st_r == M_IDLE) begin
                        bc_nxt = (q_data == ADDR_BCAST);
                    end
                    st_nxt = q_last ? M_CRCL : M_SEND;
                end
            end
            M_CRCL: begin
                mv_nxt = 1'b1;
                md_nxt = crc_r[7:0];
                st_nxt = M_CRCH;
            end
            M_CRCH: begin
                mv_nxt = 1'b1;
                md_nxt = crc_r[15:8];
                // Broadcasts need the longer spacing before the next one.
                gap_nxt = bc_r ? silent + BCAST_EXTRA : silent;
                st_nxt = M_GAP;
            end
            M_GAP: begin
                // Driver drops only after the high CRC byte has gone out.
                de_nxt = 1'b0;
                if (gap_r <= 32'h0000_0001) begin
                    st_nxt = M_IDLE;
                end else begin
                    gap_nxt = gap_r - 1;
                end
            end
            default: begin
                st_nxt = M_IDLE;
            end
        endcase
    end

    // Sender registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= M_IDLE;
            crc_r <= CRC_INIT;
            bc_r <= 1'b0;
            gap_r <= 32'h0000_0000;
            mv_r <= 1'b0;
            md_r <= 8'h00;
            me_r <= 1'b0;
            de_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            crc_r <= crc_nxt;
            bc_r <= bc_nxt;
            gap_r <= gap_nxt;
            mv_r <= mv_nxt;
            md_r <= md_nxt;
            me_r <= me_nxt;
            de_r <= de_nxt;
        end
    end

    // Response collector; a silent gap closes the response frame.
    always_comb begin
        rin_nxt = rin_r;
        rv_nxt = 1'b0;
        rd_nxt = 1'b0;
        ok_nxt = ok_r;
        rdat_nxt = rdat_r;
        rcrc_nxt = rcrc_r;
        ridle_nxt = rin_r ? ridle_r + 1 : 32'h0000_0000;
        if (link.s_valid) begin
            rin_nxt = 1'b1;
            rv_nxt = 1'b1;
            rdat_nxt = link.s_data;
            rcrc_nxt = crc_byte(rin_r ? rcrc_r : CRC_INIT, link.s_data);
            ridle_nxt = 32'h0000_0000;
        end else if (rin_r && ridle_r >= silent - 1) begin
            rin_nxt = 1'b0;
            rd_nxt = 1'b1;
            ok_nxt = (rcrc_r == 16'h0000);
        end
    end

    // Collector registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rin_r <= 1'b0;
            rv_r <= 1'b0;
            rd_r <= 1'b0;
            ok_r <= 1'b0;
            rdat_r <= 8'h00;
            rcrc_r <= CRC_INIT;
            ridle_r <= 32'h0000_0000;
        end else begin
            rin_r <= rin_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            ok_r <= ok_nxt;
            rdat_r <= rdat_nxt;
            rcrc_r <= rcrc_nxt;
            ridle_r <= ridle_nxt;
        end
    end

    assign link.m_valid = mv_r;
    assign link.m_data = md_r;
    assign link.m_err = me_r;
    assign link.m_de = de_r;
    assign r_valid = rv_r;
    assign r_data = rdat_r;
    assign r_done = rd_r;
    assign r_crc_ok = ok_r;
endmodule

// file: test/mbf_link_properties.sv
/* Link assertions for the framer.
   Assumes the silent time spans more than 8 cycles. */
`timescale 1ns/100ps
module mbf_link_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic m_valid,
    input wire logic [7:0] m_data,
    input wire logic m_de,
    input wire logic s_valid,
    input wire logic s_de
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic bc_r; // The last frame went to address zero.
    logic de_r; // Master driver one cycle ago, marks a first byte.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bc_r <= 1'b0;
            de_r <= 1'b0;
        end else begin
            de_r <= m_de;
            bc_r <= (m_valid && !de_r) ? (m_data == 8'h00) : bc_r;
        end
    end
    sequence tx_start;
        $rose(s_de);
    endsequence
    a_drivers_apart: assert property (!(m_de && s_de))
        else $error("both ends drive");
    a_mbyte_framed: assert property (m_valid |-> m_de)
        else $error("master byte outside frame");
    a_sbyte_framed: assert property (s_valid |-> s_de)
        else $error("slave byte outside frame");
    a_turn_quiet: assert property (tx_start |-> !s_valid [*8])
        else $error("response too early");
    a_turn_bound: assert property (tx_start |-> ##[1:300] s_valid)
        else $error("response never starts");
    a_bcast_silent: assert property (bc_r |-> !s_de)
        else $error("reply to broadcast");
    a_master_gap: assert property ($fell(m_de) |-> !m_de [*8])
        else $error("frames too close");
    a_end_first: assert property ($fell(m_de) |-> !s_de [*8])
        else $error("reply before frame end");
endmodule

// file: test/tb_modbus_rtu_slave_framer.sv
/* Bench: master and slave ends joined by the link.
   Assumes shortened silent, wait and millisecond counts. */
`timescale 1ns/100ps
module tb_modbus_rtu_slave_framer;
    typedef struct {logic [7:0] a, f; logic d, k;} mbf_row_t;
    logic clk = 0, rst = 1, q_valid = 0, q_last = 0, q_err = 0;
    logic rsp_valid = 0, rsp_last = 0, full_seen = 0;
    logic [7:0] q_data = 0, rsp_data = 0, r_data, qry_data, fr[9];
    logic [7:0] mq[$], sq[$];
    logic [13:0] timeout_ms = 14'h0000, wait_cnt = 14'h0005;
    logic [7:0] my_addr = 8'h01;
    logic [2:0] rate_sel = 3'h1;
    logic q_ready, r_valid, r_done, r_crc_ok, qry_valid, qry_done;
    logic qry_bcast, qry_known, rsp_ready, rsp_busy, timeout_alarm;
    int fail_count = 0, num_checks = 0, cyc = 0, done_n = 0, rd_n = 0, d0;
    int lm = 0, lp = 0, dc = 0, fb = 0; // Cycle stamps of link events.
    localparam int SL = 30, SF = 20, BX = 10; // Shortened silent times.
    // Address, code, accepted, known; 07h is unsupported but unicast.
    mbf_row_t rows[10] = '{'{8'h01, 8'h03, 1, 1}, '{8'h01, 8'h06, 1, 1},
        '{8'h01, 8'h08, 1, 1}, '{8'h01, 8'h10, 1, 1}, '{8'h00, 8'h06, 1, 1},
        '{8'h00, 8'h10, 1, 1}, '{8'h00, 8'h03, 0, 1}, '{8'h00, 8'h08, 0, 1},
        '{8'h02, 8'h06, 0, 1}, '{8'h01, 8'h07, 1, 0}};
    mbf_link_if link ();
    mbf_slave_end #(.SILENT_SLOW(SL), .SILENT_FAST(SF), .WAIT_UNIT(2),
        .MS_TICK(10)) u_mbf_slave_end (.clk, .rst, .link, .my_addr,
        .rate_sel, .wait_cnt, .timeout_ms, .qry_valid,
        .qry_data, .qry_done, .qry_bcast, .qry_known, .rsp_valid, .rsp_data,
        .rsp_last, .rsp_ready, .rsp_busy, .timeout_alarm);
    mbf_master_end #(.SILENT_SLOW(SL), .SILENT_FAST(SF), .BCAST_EXTRA(BX))
        u_mbf_master_end (.clk, .rst, .link, .rate_sel, .q_valid,
        .q_data, .q_last, .q_err, .q_ready, .r_valid, .r_data, .r_done,
        .r_crc_ok);
    mbf_link_properties u_mbf_link_properties (.clk, .rst,
        .m_valid(link.m_valid), .m_data(link.m_data), .m_de(link.m_de),
        .s_valid(link.s_valid), .s_de(link.s_de));
    always #5 clk = ~clk;
    // Byte capture, event counts and the hang limit.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (link.m_valid && mq.size() == 0) fb <= cyc;
        if (link.m_valid) mq.push_back(link.m_data);
        if (link.m_valid) lm <= cyc;
        if (qry_done) dc <= cyc;
        if (link.s_valid) sq.push_back(link.s_data);
        done_n <= done_n + qry_done;
        rd_n <= rd_n + r_done;
        if (!rsp_ready) full_seen <= 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    function automatic logic [15:0] crc(input logic [7:0] q[$], int n);
        logic [15:0] c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // Sends fr[0..n-1]; the slave must close the frame within 60 cycles.
    task send(input int n, input logic e);
        mq = {};
        sq = {};
        d0 = done_n;
        while (!q_ready) @(negedge clk);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            q_valid <= i < n;
            q_data <= fr[i % 9];
            q_last <= i == n - 1;
            q_err <= e;
        end
        for (int w = 0; w < 60 && done_n == d0; w++) @(negedge clk);
    endtask
    // Pushes n reply bytes back to back; above 16 bytes the store fills before sending.
    task respond(input int n);
        int r0;
        r0 = rd_n;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            rsp_valid <= i < n;
            rsp_data <= i[7:0];
            rsp_last <= i == n - 1;
            @(negedge clk);
            while (!rsp_ready) @(negedge clk);
        end
        for (int w = 0; w < 300 && rd_n == r0; w++) @(negedge clk);
        chk("rdone", 1, rd_n - r0);
        chk("rok", 1, r_crc_ok);
        chk("rdat", sq[$], r_data);
        chk("busy", 0, rsp_busy);
        chk("rcrc", crc(sq, sq.size() - 2), {sq[$], sq[$ - 1]});
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        chk("rst", 1, {link.s_de, link.m_de, timeout_alarm, rsp_ready});
        foreach (rows[i]) begin
            fr = '{rows[i].a, rows[i].f, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02,
                8'h5A, 8'h3C};
            lp = lm;
            send(rows[i].f == 8'h10 ? 9 : 6, 1'b0);
            chk("mcrc", crc(mq, mq.size() - 2), {mq[$], mq[$ - 1]});
            chk("qdat", mq[$], qry_data);
            if (i > 0 && rows[i - 1].a == 8'h00) begin
                chk("spc", 1, fb - lp > SF + BX);
            end
            chk("done", rows[i].d, done_n - d0);
            if (done_n > d0) begin
                chk("known", rows[i].k, qry_known);
                chk("gap", SF + 1, dc - lm);
                chk("bcast", rows[i].a == 8'h00, qry_bcast);
                if (rows[i].a != 8'h00) respond(i == 0 ? 18 : 3);
            end
            $display("row %0d ends", i);
        end
        send(6, 1'b1);
        chk("err", 0, done_n - d0);
        chk("full", 1, full_seen);
        @(posedge clk);
        rate_sel <= 3'h0;
        my_addr <= 8'h02;
        wait_cnt <= 14'h0064;
        fr[0] = 8'h02;
        fr[1] = 8'h06;
        send(6, 1'b0);
        chk("slow", SL + 1, dc - lm);
        respond(3);
        $display("slow rate test ends");
        @(posedge clk);
        timeout_ms <= 14'h0002;
        repeat (60) @(posedge clk);
        chk("alarm", 1, timeout_alarm);
        rst <= 1;
        @(posedge clk) rst <= 0;
        @(negedge clk);
        chk("rst2", 1, {link.s_de, link.m_de, timeout_alarm,
            rsp_ready});
        repeat (30) @(posedge clk);
        timeout_ms <= 14'h0000;
        repeat (3) @(posedge clk);
        chk("off", 0, timeout_alarm);
        $display("error and timeout tests end");
        end_sim();
    end
endmodule
